/* File: design/prc_defs.svh */
// Constants for the post-program RAM check
// Assumes inclusion by bare name from design files
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH
`define PRC_ADDR_W     6
`define PRC_DATA_W     8
`define PRC_DEPTH      64
`define PRC_NUM_CHECKS 2'h3
`define PRC_BASE_ADDR  6'h00
`define PRC_PATTERN0   8'ha5
`define PRC_PATTERN1   8'h5a
`define PRC_PATTERN2   8'hc3
`define PRC_FLASH_RESET 4'h8
`endif

/* File: design/prc_pkg.sv */
// Types for the post-program RAM check
// Assumes prc_defs.svh is compiled alongside
package prc_pkg;
  typedef enum logic [2:0] {
    PRC_WRITE,
    PRC_READ,
    PRC_WAIT,
    PRC_COMPARE,
    PRC_FAIL,
    PRC_DONE
  } prc_state_t;
endpackage

/* File: design/prc_ram.sv */
// Two-port block RAM, one write port, one enabled read port
// Assumes a single clock and registered read data
`timescale 1ns/10ps
`include "prc_defs.svh"
module prc_ram #(
  parameter int ADDR_W = `PRC_ADDR_W,
  parameter int DATA_W = `PRC_DATA_W,
  parameter int DEPTH  = `PRC_DEPTH
) (
  input  wire logic              clk_sys,
  input  wire logic              ce,
  input  wire logic              access_refused,
  input  wire logic              write_enable,
  input  wire logic [ADDR_W-1:0] write_port_address,
  input  wire logic [DATA_W-1:0] write_port_word,
  input  wire logic              read_enable,
  input  wire logic [ADDR_W-1:0] read_port_address,
  output logic      [DATA_W-1:0] read_word
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    // Refused accesses drop writes and return zero on reads
    if (ce && write_enable && !access_refused) begin
      mem[write_port_address] <= write_port_word;
    end
    if (ce && read_enable) begin
      read_word <= access_refused ? '0 : mem[read_port_address];
    end
  end
endmodule

/* File: design/prc_check.sv */
// Post-program RAM check state machine
// Assumes rst comes from the controller's power-on reset; flash pins pass through one register
`timescale 1ns/10ps
`include "prc_defs.svh"
// Summary of operation
// - After reset, write pattern to three addresses
// - Read back same three addresses, compare each
// - Mismatch asserts active-low tamper reset request
// - All match: do nothing, request stays high
// - Power-on reset starts the check sequence
// - RAM is 64 by 8, read enable
// - Refused RAM access is detected, forcing reset
// - Fabric halted during program or verify
// - Flash port pins stay usable while frozen
module prc_check #(
  parameter int ADDR_W = `PRC_ADDR_W,
  parameter int DATA_W = `PRC_DATA_W
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic flash_clk_in,
  input  wire logic flash_data_in,
  input  wire logic flash_data_out_in,
  input  wire logic flash_select0_in,
  input  wire logic ram_access_refused,
  output logic      flash_clk,
  output logic      flash_data_to_flash,
  output logic      flash_data_from_flash,
  output logic      flash_select0,
  output logic      checker_reset_n,
  output logic      check_done,
  output logic      check_failed
);
  prc_pkg::prc_state_t state;
  prc_pkg::prc_state_t next_state;
  logic [1:0]          index;
  logic [1:0]          next_index;
  logic                next_checker_reset_n;
  logic                next_done;
  logic                next_failed;
  logic                write_enable;
  logic                read_enable;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   read_word;
  logic [3:0]          flash_in_bus;
  logic [3:0]          flash_q;
  logic [3:0]          next_flash_q;

  localparam logic [3:0] FLASH_IDLE = `PRC_FLASH_RESET;

  function automatic logic [DATA_W-1:0] pattern_of(input logic [1:0] i);
    unique case (i)
      2'h0:    pattern_of = DATA_W'(`PRC_PATTERN0);
      2'h1:    pattern_of = DATA_W'(`PRC_PATTERN1);
      default: pattern_of = DATA_W'(`PRC_PATTERN2);
    endcase
  endfunction

  // Last address of the check window
  function automatic logic is_last(input logic [1:0] i);
    is_last = (i == `PRC_NUM_CHECKS - 2'h1);
  endfunction

  assign addr         = ADDR_W'(`PRC_BASE_ADDR) + ADDR_W'(index);
  assign write_enable = (state == prc_pkg::PRC_WRITE);
  assign read_enable  = (state == prc_pkg::PRC_READ);

  prc_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .DEPTH  (`PRC_DEPTH)
  ) u_ram (
    .clk_sys            (clk_sys),
    .ce                 (ce),
    .access_refused     (ram_access_refused),
    .write_enable       (write_enable),
    .write_port_address (addr),
    .write_port_word    (pattern_of(index)),
    .read_enable        (read_enable),
    .read_port_address  (addr),
    .read_word          (read_word)
  );

  // Sequence: write the window, then read and compare each address
  always_comb begin
    next_state = state;
    next_index = index;
    unique case (state)
      prc_pkg::PRC_WRITE: begin
        if (is_last(index)) begin
          next_index = 2'h0;
          next_state = prc_pkg::PRC_READ;
        end else begin
          next_index = index + 2'h1;
        end
      end
      prc_pkg::PRC_READ: begin
        next_state = prc_pkg::PRC_WAIT;
      end
      prc_pkg::PRC_WAIT: begin
        next_state = prc_pkg::PRC_COMPARE;
      end
      prc_pkg::PRC_COMPARE: begin
        if (read_word != pattern_of(index)) begin
          next_state = prc_pkg::PRC_FAIL;
        end else if (is_last(index)) begin
          next_state = prc_pkg::PRC_DONE;
        end else begin
          next_index = index + 2'h1;
          next_state = prc_pkg::PRC_READ;
        end
      end
      prc_pkg::PRC_FAIL: begin
        next_state = prc_pkg::PRC_DONE;
      end
      prc_pkg::PRC_DONE: begin
        next_state = prc_pkg::PRC_DONE;
      end
      default: begin
        next_state = prc_pkg::PRC_DONE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= prc_pkg::PRC_WRITE;
      index <= 2'h0;
    end else if (ce) begin
      state <= next_state;
      index <= next_index;
    end
  end

  // Status flags; the request only falls, and only rst raises it again
  always_comb begin
    next_checker_reset_n = checker_reset_n;
    next_done            = check_done;
    next_failed          = check_failed;
    if (state == prc_pkg::PRC_FAIL) begin
      next_checker_reset_n = 1'b0;
      next_failed          = 1'b1;
      next_done            = 1'b1;
    end
    if (state == prc_pkg::PRC_DONE) begin
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      checker_reset_n <= 1'b1;
      check_done      <= 1'b0;
      check_failed    <= 1'b0;
    end else if (ce) begin
      checker_reset_n <= next_checker_reset_n;
      check_done      <= next_done;
      check_failed    <= next_failed;
    end
  end

  // Flash pins bypass the enable so they keep running while frozen
  assign flash_in_bus = {flash_select0_in, flash_data_out_in, flash_data_in, flash_clk_in};

  for (genvar p = 0; p < 4; p++) begin : g_flash
    assign next_flash_q[p] = rst ? FLASH_IDLE[p] : flash_in_bus[p];
  end

  always_ff @(posedge clk_sys) begin
    flash_q <= next_flash_q;
  end

  assign flash_clk             = flash_q[0];
  assign flash_data_to_flash   = flash_q[1];
  assign flash_data_from_flash = flash_q[2];
  assign flash_select0         = flash_q[3];
endmodule

/* File: tb/prc_tamper_model.sv */
// Tamper reset macro model: a low request gives a system reset
// Assumes the bench merges sys_reset into rst
`timescale 1ns/10ps
// RAM access stays refused from a program operation until a system reset
module prc_tamper_model (
  input  wire logic clk_sys,
  input  wire logic program_done,
  input  wire logic checker_reset_n,
  output logic      sys_reset,
  output logic      ram_access_refused
);
  logic locked = 1'b0;
  always_ff @(posedge clk_sys) sys_reset <= !checker_reset_n;
  always @(posedge clk_sys) begin
    if (sys_reset === 1'b1) locked <= 1'b0;
    else if (program_done) locked <= 1'b1;
  end
  assign ram_access_refused = locked;
endmodule

/* File: tb/prc_check_checker.sv */
// Assertions on the RAM check ports
// Assumes binding onto prc_check
`timescale 1ns/10ps
module prc_check_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic flash_clk_in,
  input wire logic flash_data_in,
  input wire logic flash_select0_in,
  input wire logic flash_clk,
  input wire logic flash_data_to_flash,
  input wire logic flash_select0,
  input wire logic checker_reset_n,
  input wire logic check_done,
  input wire logic check_failed
);
  logic [3:0] cnt;
  always_ff @(posedge clk_sys) begin
    if (rst) cnt <= 4'h0;
    else if (ce && cnt != 4'hf) cnt <= cnt + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_EARLY: assert property (cnt == 4'hc |-> !check_done) else $error("done early");
  AST_ONTIME: assert property (cnt == 4'hd |-> check_done) else $error("done late");
  AST_PASS: assert property (check_done && !check_failed |-> checker_reset_n) else $error("request on pass");
  AST_FAIL: assert property (check_failed |-> !checker_reset_n) else $error("no request on fail");
  AST_HOLD: assert property ($fell(checker_reset_n) |=> !checker_reset_n[*4]) else $error("request dropped");
  AST_ONCE: assert property (check_done |=> $stable(check_done) && $stable(check_failed)) else $error("rerun");
  AST_FREEZE: assert property (!ce && !check_done |=> !check_done) else $error("ran frozen");
  AST_FLASH: assert property (1'b1 |=> flash_clk == $past(flash_clk_in) &&
    flash_select0 == $past(flash_select0_in) && flash_data_to_flash == $past(flash_data_in)) else $error("flash lag");
  cover property (check_done);
  cover property (check_failed);
  cover property (!ce ##1 ce);
  cover property ($rose(flash_clk));
endmodule
bind prc_check prc_check_checker u_chk (.*);

/* File: tb/test_prc_check.sv */
// Bench for the post-program RAM check
// Assumes design, checker and partner compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t %h %h", $time, a, e); end end
module test_prc_check;
  logic       clk_sys = 1'b0;
  logic       tb_rst = 1'b1;
  logic       ce = 1'b1;
  logic [3:0] fin = 4'h0;
  logic       program_done = 1'b0;
  logic       rst, sys_reset, fclk, fdo, fdi, fss, req_n, done, failed, refused;
  int         miscompares = 0;
  int         checked = 0;
  int         cycles = 0;
  assign rst = tb_rst || sys_reset === 1'b1;
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end
  prc_check dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .flash_clk_in(fin[0]), .flash_data_in(fin[1]),
    .flash_data_out_in(fin[2]), .flash_select0_in(fin[3]), .flash_clk(fclk), .flash_data_to_flash(fdo),
    .flash_data_from_flash(fdi), .flash_select0(fss), .checker_reset_n(req_n), .check_done(done),
    .check_failed(failed), .ram_access_refused(refused));
  prc_tamper_model partner (.clk_sys(clk_sys), .program_done(program_done), .checker_reset_n(req_n),
    .sys_reset(sys_reset), .ram_access_refused(refused));
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic restart(input logic c);
    @(posedge clk_sys) tb_rst <= 1'b1;
    ce <= c;
    repeat (6) @(posedge clk_sys);
    #1 `CHK({done, failed, req_n}, 3'b001)
    @(posedge clk_sys) tb_rst <= 1'b0;
  endtask
  task automatic t_pass();
    restart(1'b1);
    repeat (12) @(posedge clk_sys);
    #1 `CHK(done, 1'b0)
    @(posedge clk_sys);
    #1 `CHK({done, failed, req_n}, 3'b101)
    repeat (20) @(posedge clk_sys);
    #1 `CHK({done, failed, req_n}, 3'b101)
  endtask
  task automatic t_freeze();
    restart(1'b0);
    repeat (20) @(posedge clk_sys);
    #1 `CHK(done, 1'b0)
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) fin <= 4'h1 << i;
      @(posedge clk_sys);
      #1 `CHK({fss, fdi, fdo, fclk}, 4'h1 << i)
    end
    @(posedge clk_sys) ce <= 1'b1;
    repeat (13) @(posedge clk_sys);
    #1 `CHK({done, req_n}, 2'b11)
  endtask
  task automatic t_refused();
    @(posedge clk_sys) program_done <= 1'b1;
    @(posedge clk_sys) program_done <= 1'b0;
    restart(1'b1);
    repeat (7) @(posedge clk_sys);
    #1 `CHK({done, failed, req_n}, 3'b110)
    repeat (16) @(posedge clk_sys);
    #1 `CHK({done, failed, req_n}, 3'b101)
  endtask
  initial begin
    t_pass();
    t_refused();
    t_freeze();
    t_pass();
    summarize();
  end
endmodule
